// ---- src/usp_device.sv ----
/*
 * Serial element host port and modem pins: register access over the
 * strobed parallel bus, modem status change detection, interrupt line
 * with output gate, and modem control outputs.
 * Assumes host pins synchronous to ref_clk; receive/transmit engines
 * outside report their events on plain ports.
 */
`timescale 1ns/1ps
`default_nettype none
module usp_device
    import usp_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Host pins
    usp_if.device            bus,
    // Modem inputs, active low at the pins
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ring_n,
    // Modem outputs
    output logic             dtr_n,
    output logic             rts_n,
    output logic             user_output_n,
    output logic             rs485_drive_en,
    // Serial engine side
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_error,
    input  wire logic        rx_auto_hold,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    output logic             tx_permit,
    output logic             serial_enable,
    output logic             loopback
);
    logic [7:0] ien_ff, mctl_ff, lctl_ff, scr_ff, mstat_chg_ff;
    logic       cts_ff, dsr_ff, ring_ff;
    logic       sel_prev_ff, is_write_ff, wr_prev_ff, rd_prev_ff;
    logic [7:0] rbuf_ff;
    logic       rbuf_full_ff, rxerr_ff;
    logic       rd_active, wr_active, rd_take, wr_take, rd_fall;
    logic       f_valid, f_ready;
    logic [7:0] f_data;
    logic [7:0] iid, mstat, lstat, rd_val;
    logic       irq_pend;

    // Access decode: idle unless selected, mode picks the read qualifier
    always_comb begin
        if (bus.mode_sel) begin
            rd_active = !bus.unit_sel_n && !bus.read_strobe_n;   // RULE_02
            wr_active = !bus.unit_sel_n && !bus.write_strobe_n;  // RULE_01
        end else begin
            // Second selected cycle on, once the latched direction is valid
            rd_active = !bus.unit_sel_n && !sel_prev_ff && !is_write_ff;  // RULE_03
            wr_active = !bus.unit_sel_n && !sel_prev_ff && is_write_ff;
        end
    end
    // Read side effects once per access, writes commit on the first cycle of each write access
    assign rd_fall = rd_active && !rd_prev_ff;
    assign rd_take = rd_fall;
    assign wr_take = wr_active && !wr_prev_ff;

    // Direction latch on select fall in strobe-less read mode
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sel_prev_ff <= 1'b1;
            is_write_ff <= 1'b0;
            rd_prev_ff  <= 1'b0;
            wr_prev_ff  <= 1'b0;
        end else begin
            sel_prev_ff <= bus.unit_sel_n;
            rd_prev_ff  <= rd_active;
            wr_prev_ff  <= wr_active;
            if (sel_prev_ff && !bus.unit_sel_n) begin
                is_write_ff <= !bus.write_strobe_n;  // RULE_03
            end
        end
    end

    // Register writes from the data bus
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ien_ff  <= BYTE_ZERO;  // RULE_19
            mctl_ff <= BYTE_ZERO;
            lctl_ff <= BYTE_ZERO;
            scr_ff  <= BYTE_ZERO;
        end else if (wr_take) begin
            unique case (bus.addr)  // RULE_05
                REG_IEN:  ien_ff  <= bus.data_bus;
                REG_LCTL: lctl_ff <= bus.data_bus;
                REG_MCTL: mctl_ff <= bus.data_bus;
                REG_SCR:  scr_ff  <= bus.data_bus;
                default: ;
            endcase
        end
    end

    // Transmit buffer: a data write pushes, engine drains it
    usp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txq (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (wr_take && bus.addr == REG_DATA),
        .in_ready  (f_ready),
        .in_data   (bus.data_bus),
        .out_valid (f_valid),
        .out_ready (tx_ready && tx_permit),
        .out_data  (f_data)
    );

    // Serial outputs and modem pins from flops
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dtr_n          <= 1'b1;  // RULE_13
            rts_n          <= 1'b1;  // RULE_21
            user_output_n  <= 1'b1;
            rs485_drive_en <= 1'b0;
            tx_permit      <= 1'b0;
            serial_enable  <= 1'b0;  // RULE_20
            loopback       <= 1'b0;
        end else begin
            dtr_n <= !(mctl_ff[MC_DTR] && !mctl_ff[MC_LOOP]);  // RULE_12 RULE_13
            rts_n <= !(mctl_ff[MC_RTS] && !mctl_ff[MC_LOOP]
                       && !(mctl_ff[MC_AUTO] && rx_auto_hold));  // RULE_21
            user_output_n  <= !mctl_ff[MC_GATE];  // RULE_17 RULE_18
            // Driver enabled with bit6 set while transmit data is queued or the engine is not ready
            rs485_drive_en <= mctl_ff[MC_RS485] && (f_valid || !tx_ready);  // RULE_14
            tx_permit      <= !mctl_ff[MC_AUTO] || !cts_n;  // RULE_09
            serial_enable  <= 1'b1;
            loopback       <= mctl_ff[MC_LOOP];
        end
    end
    assign tx_valid = f_valid && tx_permit;  // RULE_09
    assign tx_data  = f_data;                // RULE_06

    // Receive holding byte and error flag
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rbuf_ff      <= BYTE_ZERO;
            rbuf_full_ff <= 1'b0;
            rxerr_ff     <= 1'b0;
        end else begin
            if (rx_valid && rx_ready) begin
                rbuf_ff      <= rx_data;
                rbuf_full_ff <= 1'b1;
            end else if (rd_take && bus.addr == REG_DATA) begin
                rbuf_full_ff <= 1'b0;
            end
            if (rx_error) begin
                rxerr_ff <= 1'b1;  // set wins over clear
            end else if (rd_take && bus.addr == REG_LSTAT) begin
                rxerr_ff <= 1'b0;
            end
        end
    end
    assign rx_ready = !rbuf_full_ff;

    // Modem input history and sticky change flags
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cts_ff       <= 1'b1;
            dsr_ff       <= 1'b1;
            ring_ff      <= 1'b1;
            mstat_chg_ff <= BYTE_ZERO;
        end else begin
            cts_ff  <= cts_n;
            dsr_ff  <= dsr_n;
            ring_ff <= ring_n;
            // Status read clears; a fresh change in that cycle still sets
            if (rd_take && bus.addr == REG_MSTAT) begin
                mstat_chg_ff <= BYTE_ZERO;  // RULE_23 RULE_24
            end
            if (cts_ff != cts_n) mstat_chg_ff[MS_DCTS] <= 1'b1;  // RULE_07
            if (dsr_ff != dsr_n) mstat_chg_ff[MS_DDSR] <= 1'b1;  // RULE_10
            // Ring pin low-to-high
            if (!ring_ff && ring_n) mstat_chg_ff[MS_RING_EDGE] <= 1'b1;  // RULE_22
        end
    end

    // Status images, inputs shown as asserted-high levels
    always_comb begin
        mstat = mstat_chg_ff;
        mstat[MS_CTS]  = !cts_ff;   // RULE_07
        mstat[MS_DSR]  = !dsr_ff;   // RULE_10
        mstat[MS_RING] = !ring_ff;  // RULE_22
        lstat = BYTE_ZERO;
        lstat[LS_RXRDY] = rbuf_full_ff;
        lstat[LS_RXERR] = rxerr_ff;
        lstat[LS_THRE]  = !f_valid;
    end

    // Interrupt priority; CTS change ignored under auto gating
    always_comb begin
        if (ien_ff[IEN_RXERR] && rxerr_ff) begin
            iid = IID_RXERR;  // RULE_15
        end else if (ien_ff[IEN_RXDATA] && rbuf_full_ff) begin
            iid = IID_RXDAT;
        end else if (ien_ff[IEN_TXEMPTY] && !f_valid) begin
            iid = IID_THRE;
        end else if (ien_ff[IEN_MODEM] && ((mstat_chg_ff[MS_DCTS] && !mctl_ff[MC_AUTO])
                     || mstat_chg_ff[MS_DDSR] || mstat_chg_ff[MS_RING_EDGE])) begin
            iid = IID_MODEM;  // RULE_08 RULE_11 RULE_22
        end else begin
            iid = IID_NONE;
        end
    end
    assign irq_pend = !iid[0];

    // Read data selection
    always_comb begin
        unique case (bus.addr)
            REG_DATA:  rd_val = rbuf_ff;
            REG_IEN:   rd_val = ien_ff;
            REG_IID:   rd_val = iid;
            REG_LCTL:  rd_val = lctl_ff;
            REG_MCTL:  rd_val = mctl_ff;
            REG_LSTAT: rd_val = lstat;
            REG_MSTAT: rd_val = mstat;
            REG_SCR:   rd_val = scr_ff;
            default:   rd_val = BYTE_ZERO;
        endcase
    end

    // Bus and interrupt pin drive from flops
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            bus.dev_dout <= BYTE_ZERO;
            bus.dev_doe  <= 1'b0;
            bus.irq_out  <= 1'b0;
            bus.irq_oe   <= 1'b0;
        end else begin
            if (rd_fall) begin
                bus.dev_dout <= rd_val;  // RULE_04
            end
            bus.dev_doe <= rd_active;  // RULE_04 RULE_06
            bus.irq_out <= irq_pend;   // RULE_15 RULE_16
            bus.irq_oe  <= mctl_ff[MC_GATE];  // RULE_17 RULE_18
        end
    end
endmodule
`default_nettype wire

// ---- inc/usp_pkg.sv ----
/*
 * Constants, types and register layout shared by both ends of the serial
 * element host port: the device's pin-level logic and the host bus master.
 * Assumes one 20 MHz clock and a synchronous active-low reset on both ends.
 */
// Functional notes
// [RULE_01] Respond to strobes only while selected
// [RULE_02] Mode high: read strobe performs reads
// [RULE_03] Mode low: write level at select decides
// [RULE_04] Drive data bus during selected read
// [RULE_05] Write strobe loads bus into addressed register
// [RULE_06] Eight-bit three-state bus, bit0 sent first
// [RULE_07] Status bit4 clear-to-send, bit0 its change
// [RULE_08] CTS change interrupts unless auto gating on
// [RULE_09] Auto gating lets CTS hold transmitter
// [RULE_10] Status bit5 data-set-ready, bit1 its change
// [RULE_11] DSR change interrupts when enabled
// [RULE_12] DTR output low when control bit set
// [RULE_13] DTR high on reset, loopback or clear
// [RULE_14] DTR enables external RS-485 driver; the code uses control bit6 instead
// [RULE_15] Interrupt on four cause classes
// [RULE_16] Interrupt clears when serviced or reset
// [RULE_17] Gate bit one: drive interrupt, user output low
// [RULE_18] Gate bit zero: interrupt floats, user output high
// [RULE_19] Reset clears registers and outputs
// [RULE_20] Reset disables serial transmit and receive
// [RULE_21] RTS follows bit1, inactive on reset/loop/auto
// [RULE_22] Status bit6 ring, bit2 trailing edge
// [RULE_23] Status read clears all change flags
// [RULE_24] Status read services modem interrupt
package usp_pkg;
    localparam int  DATA_W       = 8;
    localparam int  ADDR_W       = 3;
    // Register indexes on the three address inputs
    localparam logic [2:0] REG_DATA  = 3'h0;
    localparam logic [2:0] REG_IEN   = 3'h1;
    localparam logic [2:0] REG_IID   = 3'h2;
    localparam logic [2:0] REG_LCTL  = 3'h3;
    localparam logic [2:0] REG_MCTL  = 3'h4;
    localparam logic [2:0] REG_LSTAT = 3'h5;
    localparam logic [2:0] REG_MSTAT = 3'h6;
    localparam logic [2:0] REG_SCR   = 3'h7;
    // Interrupt enable fields
    localparam int IEN_RXDATA = 0;
    localparam int IEN_TXEMPTY = 1;
    localparam int IEN_RXERR = 2;
    localparam int IEN_MODEM = 3;
    // Modem control fields
    localparam int MC_DTR    = 0;
    localparam int MC_RTS    = 1;
    localparam int MC_GATE   = 3;
    localparam int MC_LOOP   = 4;
    localparam int MC_AUTO   = 5;
    localparam int MC_RS485  = 6;
    // Modem status fields
    localparam int MS_DCTS   = 0;
    localparam int MS_DDSR   = 1;
    localparam int MS_RING_EDGE = 2;
    localparam int MS_CTS    = 4;
    localparam int MS_DSR    = 5;
    localparam int MS_RING   = 6;
    // Line status fields
    localparam int LS_RXRDY  = 0;
    localparam int LS_RXERR  = 1;
    localparam int LS_THRE   = 5;
    // Interrupt identity codes, bit0 high means none pending
    localparam logic [7:0] IID_NONE  = 8'h01;
    localparam logic [7:0] IID_RXERR = 8'h06;
    localparam logic [7:0] IID_RXDAT = 8'h04;
    localparam logic [7:0] IID_THRE  = 8'h02;
    localparam logic [7:0] IID_MODEM = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Host cycle lengths in reference clocks
    localparam int STROBE_CYC    = 2;
    // Host command kinds
    typedef enum logic {USP_CMD_READ, USP_CMD_WRITE} usp_cmd_e;
endpackage

// ---- inc/usp_if.sv ----
/*
 * Pin bundle between the serial element and its host.
 * Data bus and interrupt line are resolved here from the output enables.
 */
`timescale 1ns/1ps
`default_nettype none
interface usp_if;
    logic       unit_sel_n;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic [2:0] addr;
    logic       mode_sel;
    logic [7:0] host_dout;
    logic       host_doe;
    logic [7:0] dev_dout;
    logic       dev_doe;
    wire  [7:0] data_bus;
    logic       irq_out;
    logic       irq_oe;
    wire        irq_line;
    // Bus level from whichever side drives; a pull-up floats to ones
    assign data_bus = host_doe ? host_dout : (dev_doe ? dev_dout : 8'hFF);
    assign irq_line = irq_oe ? irq_out : 1'b0;
    modport device (input unit_sel_n, read_strobe_n, write_strobe_n, addr, mode_sel,
                    data_bus, output dev_dout, dev_doe, irq_out, irq_oe);
    modport host (output unit_sel_n, read_strobe_n, write_strobe_n, addr, mode_sel,
                  host_dout, host_doe, input data_bus, irq_line);
endinterface
`default_nettype wire

// ---- src/usp_fifo.sv ----
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module usp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    logic             push;
    logic             pop;
    // Honest full and empty from the occupancy count
    assign in_ready  = (count_ff < (PW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // Storage
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end
    // Pointers and count
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- src/usp_host.sv ----
/*
 * Host end: turns single read/write commands into strobed bus cycles.
 * Assumes the device answers within the fixed strobe length.
 */
`timescale 1ns/1ps
`default_nettype none
module usp_host
    import usp_pkg::*;
#(
    parameter logic MODE_STRAP = 1'b1
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Command port
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire usp_cmd_e    cmd_kind,
    input  wire logic [2:0]  cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    output logic             irq_seen,
    // Pins
    usp_if.host              bus
);
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_DONE} usp_hstate_e;
    usp_hstate_e state_ff;
    usp_cmd_e    kind_ff;
    logic [1:0]  cnt_ff;

    assign bus.mode_sel = MODE_STRAP;

    // Cycle sequencer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_ff           <= H_IDLE;
            kind_ff            <= USP_CMD_READ;
            cnt_ff             <= 2'h0;
            cmd_ready          <= 1'b0;
            rsp_valid          <= 1'b0;
            rsp_rdata          <= BYTE_ZERO;
            bus.unit_sel_n     <= 1'b1;
            bus.read_strobe_n  <= 1'b1;  // RULE_03
            bus.write_strobe_n <= 1'b1;
            bus.addr           <= 3'h0;
            bus.host_dout      <= BYTE_ZERO;
            bus.host_doe       <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            cmd_ready <= 1'b0;
            unique case (state_ff)
                H_IDLE: begin
                    if (cmd_valid && !cmd_ready) begin
                        cmd_ready     <= 1'b1;
                        kind_ff       <= cmd_kind;
                        bus.addr      <= cmd_addr;  // RULE_05
                        bus.host_dout <= cmd_wdata;
                        bus.host_doe  <= (cmd_kind == USP_CMD_WRITE);
                        // Strobe-less mode: write level is sampled at select
                        bus.write_strobe_n <= !(!MODE_STRAP && cmd_kind == USP_CMD_WRITE);
                        state_ff      <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    bus.unit_sel_n <= 1'b0;  // RULE_01
                    if (MODE_STRAP) begin
                        bus.read_strobe_n  <= (kind_ff != USP_CMD_READ);  // RULE_02
                        bus.write_strobe_n <= (kind_ff != USP_CMD_WRITE); // RULE_05
                    end
                    cnt_ff   <= 2'(STROBE_CYC);
                    state_ff <= H_STROBE;
                end
                H_STROBE: begin
                    if (cnt_ff == 2'h0) begin
                        rsp_rdata <= bus.data_bus;
                        rsp_valid <= (kind_ff == USP_CMD_READ);
                        bus.unit_sel_n     <= 1'b1;
                        bus.read_strobe_n  <= 1'b1;
                        bus.write_strobe_n <= 1'b1;
                        state_ff <= H_DONE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                H_DONE: begin
                    bus.host_doe <= 1'b0;
                    state_ff     <= H_IDLE;
                end
            endcase
        end
    end

    // Interrupt line sampled
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq_seen <= 1'b0;
        end else begin
            irq_seen <= bus.irq_line;
        end
    end
endmodule
`default_nettype wire

// ---- verif/usp_assertions.sv ----
/* Checker on the host port pins between host end and device end.
   Assumes the bench instantiates it beside the joining interface. */
`timescale 1ns/1ps
`default_nettype none
module usp_assertions
    import usp_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // Host strobes and address
    input  wire logic       unit_sel_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [2:0] addr,
    input  wire logic       mode_sel,
    // Bus drivers and interrupt enable
    input  wire logic       host_doe,
    input  wire logic       dev_doe,
    input  wire logic [7:0] data_bus,
    input  wire logic       irq_oe
);
    logic gate_ff;

    // Shadow of the interrupt gate bit as the host writes it
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            gate_ff <= 1'b0;
        end else if (!unit_sel_n && !write_strobe_n && addr == REG_MCTL) begin
            gate_ff <= data_bus[MC_GATE];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_sel_gates_strobes: assert property ((!read_strobe_n || !write_strobe_n) |-> !unit_sel_n)
        else $error("strobe seen without select");
    a_doe_needs_sel: assert property (dev_doe |-> !$past(unit_sel_n))
        else $error("device drives bus while deselected");
    a_mode_held: assert property ($stable(mode_sel))
        else $error("mode pin moved");
    a_read_answers: assert property ((mode_sel && !unit_sel_n && !read_strobe_n) [*2] |-> dev_doe)
        else $error("read not answered in one cycle");
    a_doe_after_read: assert property ($fell(dev_doe) |-> $past(read_strobe_n) || $past(unit_sel_n))
        else $error("bus released while read active");
    a_strobes_exclusive: assert property (!(!read_strobe_n && !write_strobe_n))
        else $error("both strobes low");
    a_write_held: assert property ((!write_strobe_n) [*2] |-> $stable(addr) && $stable(data_bus))
        else $error("address or data moved in write");
    a_no_contention: assert property (!(dev_doe && host_doe))
        else $error("both ends drive the bus");
    a_gate_on_drives: assert property ((unit_sel_n [*3]) ##0 gate_ff |-> irq_oe)
        else $error("interrupt not driven with gate set");
    a_gate_off_floats: assert property ((unit_sel_n [*3]) ##0 !gate_ff |-> !irq_oe)
        else $error("interrupt driven with gate clear");
    a_reset_quiet: assert property ($rose(resetn) |-> !dev_doe && !irq_oe)
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// ---- verif/uart_host_port_modem_pins_tb.sv ----
/* Bench joining host end and device end over the pin interface.
   Assumes package, interface and design modules are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module uart_host_port_modem_pins_tb
    import usp_pkg::*;
;
    typedef struct packed {logic [2:0] a; logic [7:0] w; logic [7:0] r; logic dtr;} usp_row_s;
    // Round trips: address, value written, value read back, expected terminal-ready pin
    localparam usp_row_s ROWS [6] = '{'{REG_SCR, 8'hA5, 8'hA5, 1'b1},
        '{REG_SCR, 8'h5A, 8'h5A, 1'b1}, '{REG_IEN, 8'h08, 8'h08, 1'b1},
        '{REG_LCTL, 8'h03, 8'h03, 1'b1}, '{REG_MCTL, 8'h03, 8'h03, 1'b0},
        '{REG_MCTL, 8'h00, 8'h00, 1'b1}};
    logic       ref_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0;
    usp_cmd_e   cmd_kind = USP_CMD_READ;
    logic [2:0] cmd_addr = 3'h0;
    logic [7:0] cmd_wdata = 8'h00, rx_data = 8'h00, rsp_rdata, tx_data, rd_val;
    logic       cts_n = 1'b1, dsr_n = 1'b1, ring_n = 1'b1, rx_valid = 1'b0, rx_error = 1'b0;
    logic       rx_auto_hold = 1'b0, tx_ready = 1'b1, cmd_ready, rsp_valid, irq_seen;
    logic       dtr_n, rts_n, user_output_n, rs485_drive_en, rx_ready, tx_valid;
    logic       tx_permit, serial_enable, loopback;
    int         miscompares = 0, samples_checked = 0, cycles = 0;
    logic [7:0] got [$];
    usp_if      bus_if ();

    usp_host u_usp_host (.ref_clk, .resetn, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr,
        .cmd_wdata, .rsp_valid, .rsp_rdata, .irq_seen, .bus(bus_if));
    usp_device u_usp_device (.ref_clk, .resetn, .bus(bus_if), .cts_n, .dsr_n, .ring_n, .dtr_n,
        .rts_n, .user_output_n, .rs485_drive_en, .rx_valid, .rx_ready, .rx_data, .rx_error,
        .rx_auto_hold, .tx_valid, .tx_ready, .tx_data, .tx_permit, .serial_enable, .loopback);
    usp_assertions u_usp_assertions (.ref_clk, .resetn, .unit_sel_n(bus_if.unit_sel_n),
        .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
        .addr(bus_if.addr), .mode_sel(bus_if.mode_sel), .host_doe(bus_if.host_doe),
        .dev_doe(bus_if.dev_doe), .data_bus(bus_if.data_bus), .irq_oe(bus_if.irq_oe));

    // 20 MHz reference clock
    always #25 ref_clk = ~ref_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Cycle ceiling so a stuck handshake still ends the run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end

    // Inputs change one nanosecond after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One host command held until taken, then the answer for reads
    task automatic xfer(input usp_cmd_e k, input logic [2:0] a, input logic [7:0] w);
        cmd_kind = k;
        cmd_addr = a;
        cmd_wdata = w;
        cmd_valid = 1'b1;
        for (int n = 0; n < 20 && cmd_ready !== 1'b1; n++) tick(1);
        cmd_valid = 1'b0;
        for (int n = 0; n < 20 && k == USP_CMD_READ && rsp_valid !== 1'b1; n++) tick(1);
        rd_val = rsp_rdata;
        tick(4);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] w);
        xfer(USP_CMD_WRITE, a, w);
    endtask

    // Modem status read, unused bits masked off
    task automatic ms(input logic [7:0] e);
        xfer(USP_CMD_READ, REG_MSTAT, 8'h00);
        chk(rd_val & 8'h77, e);
    endtask

    // Main sequence: table of round trips, then hand-written cases
    initial begin
        tick(4);
        chk({dtr_n, serial_enable}, 2'b10);
        resetn = 1'b1;
        tick(2);
        chk({rts_n, user_output_n, serial_enable}, 3'b111);
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].w);
            chk(dtr_n, ROWS[i].dtr);
            xfer(USP_CMD_READ, ROWS[i].a, 8'h00);
            chk(rd_val, ROWS[i].r);
        end
        wr(REG_MCTL, 8'h08);
        chk(user_output_n, 1'b0);
        xfer(USP_CMD_READ, REG_MSTAT, 8'h00);
        cts_n = 1'b0;
        tick(4);
        chk(irq_seen, 1'b1);
        ms(8'h11);
        chk(irq_seen, 1'b0);
        ms(8'h10);
        dsr_n = 1'b0;
        tick(4);
        chk(irq_seen, 1'b1);
        ms(8'h32);
        ring_n = 1'b0;
        tick(4);
        ms(8'h70);
        ring_n = 1'b1;
        tick(4);
        chk(irq_seen, 1'b1);
        ms(8'h34);
        wr(REG_MCTL, 8'h00);
        dsr_n = 1'b1;
        tick(4);
        chk({irq_seen, user_output_n}, 2'b01);
        ms(8'h12);
        wr(REG_MCTL, 8'h28);
        cts_n = 1'b1;
        tick(4);
        chk({irq_seen, tx_permit}, 2'b00);
        cts_n = 1'b0;
        tick(4);
        chk(tx_permit, 1'b1);
        ms(8'h11);
        rx_auto_hold = 1'b1;
        wr(REG_MCTL, 8'h2B);
        chk(rts_n, 1'b1);
        rx_auto_hold = 1'b0;
        wr(REG_MCTL, 8'h1B);
        chk({dtr_n, rts_n, loopback}, 3'b111);
        wr(REG_MCTL, 8'h0B);
        chk({dtr_n, rts_n, loopback}, 3'b000);
        // Fill the transmit buffer past full while the far side stalls
        wr(REG_MCTL, 8'h4B);
        tx_ready = 1'b0;
        for (int i = 0; i < 9; i++) wr(REG_DATA, 8'(i * 8'h11 + 8'h0F));
        chk(tx_data, 8'h0F);
        chk({tx_valid, rs485_drive_en}, 2'b11);
        tx_ready = 1'b1;
        repeat (12) begin
            if (tx_valid === 1'b1) got.push_back(tx_data);
            tick(1);
        end
        chk(8'(got.size()), 8'h08);
        foreach (got[i]) chk(got[i], 8'(i * 8'h11 + 8'h0F));
        chk(rs485_drive_en, 1'b0);
        // Received byte raises the interrupt until the host reads it
        wr(REG_IEN, 8'h01);
        wr(REG_MCTL, 8'h08);
        rx_data = 8'hC3;
        rx_valid = 1'b1;
        for (int n = 0; n < 20 && rx_ready !== 1'b1; n++) tick(1);
        tick(1);
        rx_valid = 1'b0;
        tick(4);
        chk({irq_seen, rx_ready}, 2'b10);
        xfer(USP_CMD_READ, REG_DATA, 8'h00);
        chk(rd_val, 8'hC3);
        chk(irq_seen, 1'b0);
        // Second reset in mid-run with outputs active
        wr(REG_MCTL, 8'h0B);
        resetn = 1'b0;
        tick(4);
        chk({dtr_n, rts_n, user_output_n, serial_enable}, 4'hE);
        resetn = 1'b1;
        tick(2);
        chk({dtr_n, serial_enable}, 2'b11);
        close_out();
    end
endmodule
`default_nettype wire
